// ### design/cfg_datagram_handler.sv
// configuration datagram decoder, record store and reply generator
// Contract
// - read request code 02h, slot, length
// - conventional read returns 6 to 128 bytes
// - requested length clamped, never rejected
// - bytes beyond stored record read zero
// - intelligent read: slot low, packet high nibble
// - packets never exceed 128 bytes
// - slot 0 read selector: own or group
// - reply code 03h, slot, length, data
// - write code 04h, laid out like reply
// - slot 0 is the node's own record
// - begin/end framed writes commit atomically
// - end datagram carries 16-bit byte total
// - intelligent write: slot, packet nibbles, length
// - slot 0 write selector: own or group
// - own record starts FF then eleven zeros
// - discrete input record: 45h,0,0,0, length 13
// - option bit: default or hold last
// - option bit: fault reporting enabled/disabled
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cfg_datagram_handler
  import cfg_dgram_pkg::*;
#(
  parameter int HOLD_BIT  = HOLD_BIT_DEF,
  parameter int FAULT_BIT = FAULT_BIT_DEF
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // incoming datagram bytes, subfunction code first
  input  wire logic        rxValid,
  output logic             rxReady,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxLast,
  // outgoing reply bytes
  output logic             txValid,
  input  wire logic        txReady,
  output logic [7:0]       txData,
  output logic             txLast,
  // per-slot discrete input options
  output logic [15:0]      holdLastState,
  output logic [15:0]      faultReportOff
);

  typedef struct packed {
    phase_e                 phase;
    logic [7:0]             cmd, idx, slotByte, lenByte, selByte, first;
    logic [7:0]             opt, retLen, stored, txPhase, txByte, aAddr;
    logic [6:0]             rec;
    logic                   grp, hdr0, hdr1, diZero, skipRd, seqOpen, seqBad;
    logic                   aValid, aWrite;
    logic [1:0][127:0][7:0] lenTab;
    logic [127:0]           act, pend;
    logic [1:0]             skip;
    logic [1:0][15:0]       hold, fault;
    logic [15:0]            holdOut, faultOut, total, intel;
    logic [3:0]             sticky;
    logic [31:0]            commits, rdata;
  } state_s;

  state_s            q;
  state_s            d;
  logic              memWe, isIntel, pktOk, grpNow, own0, shifted, diRec;
  logic              wrOk, rdOk, nb, accept;
  logic [MEM_AW-1:0] memAddr;
  logic [7:0]        memWdata, memRdata, clampConv, clampIntel;
  logic [7:0]        j, txOff, curLen;
  logic [3:0]        setSt, clrSt, slotN, pktN;

  // read length bounds for the two module kinds
  range_clamp #(.W(8), .LO(CONV_MIN), .HI(PKT_MAX)) uConv (
    .val     (q.lenByte),
    .clamped (clampConv)
  );
  range_clamp #(.W(8), .LO(INTEL_MIN), .HI(PKT_MAX)) uIntel (
    .val     (q.lenByte),
    .clamped (clampIntel)
  );

  // two banks of 128 records of 128 bytes
  cfg_mem #(.AW(MEM_AW), .DW(8)) uMem (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (memWe),
    .addr  (memAddr),
    .wdata (memWdata),
    .rdata (memRdata)
  );

  // next-state logic for the whole block
  always_comb begin
    d        = q;
    memWe    = 1'b0;
    memAddr  = '0;
    memWdata = rxData;
    setSt    = '0;
    clrSt    = '0;
    grpNow   = 1'b0;
    wrOk     = 1'b0;
    rdOk     = 1'b0;
    slotN    = q.slotByte[3:0];
    pktN     = q.slotByte[7:4];
    // slot 0 is always packetised, its length varies
    isIntel  = q.intel[slotN] || (slotN == 4'h0);
    pktOk    = isIntel ? (pktN < PKT_LIMIT) : (pktN == 4'h0);
    j        = 8'(q.idx - HDR_BYTES - {7'h00, q.grp});
    txOff    = 8'(q.txPhase - PH_DATA);
    own0     = (q.rec == OWN_REC);
    curLen   = q.lenTab[q.act[q.rec]][q.rec];
    nb       = ~q.act[q.rec];
    shifted  = own0 && (j == 8'(q.lenByte + 8'h01)) && (q.first == SEL_OWN);
    diRec    = !isIntel && (q.first == DI_TYPE);

    case (q.phase)
      // subfunction code opens a datagram
      ST_IDLE: begin
        if (rxValid) begin
          d.cmd      = rxData;
          d.idx      = '0;
          d.grp      = 1'b0;
          d.hdr0     = 1'b1;
          d.hdr1     = 1'b1;
          d.diZero   = 1'b1;
          d.first    = '0;
          d.opt      = '0;
          d.slotByte = '0;
          d.lenByte  = '0;
          d.selByte  = SEL_OWN;
          d.phase    = rxLast ? ST_FINISH : ST_BODY;
        end
      end
      // payload bytes, write data goes straight to the spare bank
      ST_BODY: begin
        if (rxValid) begin
          if (q.idx == POS_SLOT) begin
            d.slotByte = rxData;
            d.rec      = {1'b0, rxData[3:0], rxData[5:4]};
          end
          if (q.idx == POS_LEN) begin
            d.lenByte = rxData;
          end
          if (q.idx == POS_SEL) begin
            d.selByte = rxData;
            if (slotN == 4'h0 && pktN == 4'h0 && rxData >= SEL_GRP_LO && rxData <= SEL_GRP_HI) begin
              grpNow = 1'b1;
              d.grp  = 1'b1;
              d.rec  = 7'(GROUP_BASE + rxData[6:0] - SEL_GRP_LO[6:0]);
            end
          end
          if (q.cmd == SUB_WRITE && q.idx >= POS_SEL && !grpNow) begin
            if (j < PKT_MAX) begin
              memWe   = 1'b1;
              memAddr = {nb, q.rec, j[6:0]};
            end
            // header checks for both data alignments
            if (j < OWN_HDR) begin
              d.hdr0 = q.hdr0 && (rxData == ((j == POS_D0) ? OWN_TAG : 8'h00));
            end
            if (j >= POS_D1 && j <= OWN_HDR) begin
              d.hdr1 = q.hdr1 && (rxData == ((j == POS_D1) ? OWN_TAG : 8'h00));
            end
            if (j == POS_D0) begin
              d.first = rxData;
            end
            if (j >= POS_D1 && j <= DI_HDR_END) begin
              d.diZero = q.diZero && (rxData == 8'h00);
            end
            if (j == DI_OPT) begin
              d.opt = rxData;
            end
          end
          if (q.idx != 8'hFF) begin
            d.idx = 8'(q.idx + 8'h01);
          end
          if (rxLast) begin
            d.phase = ST_FINISH;
          end
        end
      end
      // act on the complete datagram
      ST_FINISH: begin
        d.phase = ST_IDLE;
        case (q.cmd)
          SUB_READ: begin
            rdOk = (q.idx >= HDR_BYTES) && (q.idx <= RD_MAX) && pktOk
                   && (slotN != 4'h0 || q.grp || q.selByte == SEL_OWN);
            if (rdOk) begin
              d.retLen  = isIntel ? clampIntel : clampConv;
              d.stored  = curLen;
              d.skipRd  = own0 && q.skip[q.act[q.rec]];
              d.txPhase = PH_CODE;
              d.phase   = ST_FETCH;
            end else begin
              setSt[STK_BADR] = 1'b1;
            end
          end
          SUB_WRITE: begin
            wrOk = (q.idx >= HDR_BYTES) && pktOk && (q.lenByte <= PKT_MAX)
                   && ((j == q.lenByte) || shifted)
                   && (!own0 || (shifted ? q.hdr1 : q.hdr0))
                   && (isIntel || curLen == 8'h00 || curLen == q.lenByte)
                   && (!diRec || (q.lenByte == DI_LEN && q.diZero));
            if (wrOk) begin
              d.lenTab[nb][q.rec] = q.lenByte;
              if (own0) begin
                d.skip[nb] = shifted;
              end
              if (!isIntel) begin
                d.hold[nb][slotN]  = diRec && q.opt[HOLD_BIT];
                d.fault[nb][slotN] = diRec && q.opt[FAULT_BIT];
              end
              if (q.seqOpen) begin
                d.pend[q.rec] = 1'b1;
                d.total       = 16'(q.total + {8'h00, q.idx});
              end else begin
                d.act[q.rec] = nb;
                d.commits    = 32'(q.commits + 32'h0000_0001);
              end
            end else begin
              setSt[STK_BADW] = 1'b1;
              if (q.seqOpen) begin
                d.seqBad = 1'b1;
              end
            end
          end
          // a second begin drops whatever was pending
          SUB_BEGIN: begin
            d.seqOpen = 1'b1;
            d.seqBad  = 1'b0;
            d.pend    = '0;
            d.total   = '0;
          end
          SUB_END: begin
            if (q.seqOpen && !q.seqBad && q.idx == END_CNT
                && {q.lenByte, q.slotByte} == q.total) begin
              d.act     = q.act ^ q.pend;
              d.commits = 32'(q.commits + 32'h0000_0001);
            end else begin
              setSt[STK_BADS] = 1'b1;
            end
            d.seqOpen = 1'b0;
            d.pend    = '0;
          end
          default: begin
            setSt[STK_BADC] = 1'b1;
          end
        endcase
      end
      // reply: address the record byte a cycle ahead
      ST_FETCH: begin
        memAddr = {q.act[q.rec], q.rec, 7'(txOff + {7'h00, q.skipRd})};
        d.phase = ST_LOAD;
      end
      ST_LOAD: begin
        if (q.txPhase == PH_CODE) begin
          d.txByte = SUB_REPLY;
        end else if (q.txPhase == PH_SLOT) begin
          d.txByte = q.slotByte;
        end else if (q.txPhase == PH_LEN) begin
          d.txByte = q.retLen;
        end else if (txOff < q.stored) begin
          d.txByte = memRdata;
        end else begin
          d.txByte = 8'h00;
        end
        d.phase = ST_OUT;
      end
      ST_OUT: begin
        if (txReady) begin
          if (q.txPhase == 8'(q.retLen + PH_LEN)) begin
            d.phase = ST_IDLE;
          end else begin
            d.txPhase = 8'(q.txPhase + 8'h01);
            d.phase   = ST_FETCH;
          end
        end
      end
      default: begin
        d.phase = ST_IDLE;
      end
    endcase

    // option outputs follow the bank in force for each slot
    for (int s = 0; s < 16; s++) begin
      d.holdOut[s]  = q.hold[q.act[{1'b0, 4'(s), 2'b00}]][s];
      d.faultOut[s] = q.fault[q.act[{1'b0, 4'(s), 2'b00}]][s];
    end

    // bus address phase is captured, data phase acts a cycle later
    accept   = hsel && hready && htrans[HTRANS_ACT];
    d.aValid = accept;
    d.aWrite = hwrite;
    d.aAddr  = haddr[7:0];
    if (q.aValid && q.aWrite) begin
      if (q.aAddr == REG_KIND) begin
        d.intel = hwdata[15:0];
      end else if (q.aAddr == REG_STATUS) begin
        clrSt = hwdata[ST_STICKY +: 4];
      end
    end
    // read data is registered so it stands through the data phase
    if (accept && !hwrite) begin
      if (haddr[7:0] == REG_KIND) begin
        d.rdata = {16'h0000, q.intel};
      end else if (haddr[7:0] == REG_STATUS) begin
        d.rdata = {20'h00000, q.sticky, 7'h00, q.seqOpen};
      end else if (haddr[7:0] == REG_COMMITS) begin
        d.rdata = q.commits;
      end else if (haddr[7:0] == REG_TOTAL) begin
        d.rdata = {16'h0000, q.total};
      end else begin
        d.rdata = 32'h0000_0000;
      end
    end
    // an error in the clearing cycle still lands
    d.sticky = (q.sticky & ~clrSt) | setSt;
  end

  // single state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // zero-wait slave, always okay
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign hrdata         = q.rdata;
  // stream handshakes
  assign rxReady        = (q.phase == ST_IDLE) || (q.phase == ST_BODY);
  assign txValid        = (q.phase == ST_OUT);
  assign txData         = q.txByte;
  assign txLast         = (q.phase == ST_OUT) && (q.txPhase == 8'(q.retLen + PH_LEN));
  assign holdLastState  = q.holdOut;
  assign faultReportOff = q.faultOut;

endmodule // cfg_datagram_handler
`default_nettype wire

// ### design/cfg_dgram_pkg.sv
// shared constants and types for the configuration datagram handler
package cfg_dgram_pkg;
  // datagram subfunction codes
  localparam logic [7:0] SUB_READ  = 8'h02;
  localparam logic [7:0] SUB_REPLY = 8'h03;
  localparam logic [7:0] SUB_WRITE = 8'h04;
  localparam logic [7:0] SUB_BEGIN = 8'h06;
  localparam logic [7:0] SUB_END   = 8'h07;
  // length limits per packet
  localparam logic [7:0] PKT_MAX   = 8'h80;
  localparam logic [7:0] CONV_MIN  = 8'h06;
  localparam logic [7:0] INTEL_MIN = 8'h01;
  localparam logic [3:0] PKT_LIMIT = 4'h4;
  // payload positions after the subfunction code
  localparam logic [7:0] POS_SLOT  = 8'h00;
  localparam logic [7:0] POS_LEN   = 8'h01;
  localparam logic [7:0] POS_SEL   = 8'h02;
  localparam logic [7:0] HDR_BYTES = 8'h02;
  localparam logic [7:0] RD_MAX    = 8'h03;
  localparam logic [7:0] END_CNT   = 8'h02;
  localparam logic [7:0] POS_D0    = 8'h00;
  localparam logic [7:0] POS_D1    = 8'h01;
  // slot 0 selector byte
  localparam logic [7:0] SEL_OWN    = 8'hFF;
  localparam logic [7:0] SEL_GRP_LO = 8'h01;
  localparam logic [7:0] SEL_GRP_HI = 8'h10;
  // record layouts
  localparam logic [7:0] OWN_TAG    = 8'hFF;
  localparam logic [7:0] OWN_HDR    = 8'h0C;
  localparam logic [7:0] DI_TYPE    = 8'h45;
  localparam logic [7:0] DI_LEN     = 8'h0D;
  localparam logic [7:0] DI_HDR_END = 8'h03;
  localparam logic [7:0] DI_OPT     = 8'h0C;
  localparam int         HOLD_BIT_DEF  = 0;
  localparam int         FAULT_BIT_DEF = 1;
  // record storage
  localparam int         MEM_AW     = 15;
  localparam logic [6:0] OWN_REC    = 7'h00;
  localparam logic [6:0] GROUP_BASE = 7'h40;
  // reply byte phases
  localparam logic [7:0] PH_CODE = 8'h00;
  localparam logic [7:0] PH_SLOT = 8'h01;
  localparam logic [7:0] PH_LEN  = 8'h02;
  localparam logic [7:0] PH_DATA = 8'h03;
  // register map and status bits
  localparam logic [7:0] REG_KIND    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_COMMITS = 8'h08;
  localparam logic [7:0] REG_TOTAL   = 8'h0C;
  localparam int         ST_STICKY   = 8;
  localparam int         STK_BADW    = 0;
  localparam int         STK_BADR    = 1;
  localparam int         STK_BADS    = 2;
  localparam int         STK_BADC    = 3;
  localparam int         HTRANS_ACT  = 1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_BODY, ST_FINISH, ST_FETCH, ST_LOAD, ST_OUT
  } phase_e;
endpackage

// ### design/cfg_mem.sv
// byte memory holding both banks of configuration records
`timescale 1ns/1ps
`default_nettype none
module cfg_mem #(
  parameter int AW = 15,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // single port
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic [DW-1:0]      rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // array has no reset so it maps onto block ram
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // registered read, one cycle after the address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[addr];
    end
  end
endmodule // cfg_mem
`default_nettype wire

// ### design/range_clamp.sv
// clamps a byte-wide length into a lower and upper bound
`timescale 1ns/1ps
`default_nettype none
module range_clamp #(
  parameter int           W  = 8,
  parameter logic [W-1:0] LO = '0,
  parameter logic [W-1:0] HI = '1
) (
  // length in and bounded length out
  input  wire logic [W-1:0] val,
  output logic [W-1:0]      clamped
);
  // short requests are raised, long ones cut
  assign clamped = (val < LO) ? LO : ((val > HI) ? HI : val);
endmodule // range_clamp
`default_nettype wire

// ### tb/cfg_datagram_handler_asserts.sv
// concurrent checks on the datagram handler ports
`timescale 1ns/1ps
`default_nettype none
module cfg_datagram_handler_asserts
  import cfg_dgram_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // streams
  input wire logic        rxValid,
  input wire logic        rxReady,
  input wire logic [7:0]  rxData,
  input wire logic        rxLast,
  input wire logic        txValid,
  input wire logic        txReady,
  input wire logic [7:0]  txData,
  input wire logic        txLast
);
  logic [7:0] txCntQ, lenQ, slotQ, rxCntQ;
  wire logic  rxEndW = rxValid && rxReady && rxLast;
  wire logic  txMoveW = txValid && txReady;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence rxEnd; rxEndW; endsequence
  sequence txMove; txMoveW; endsequence
  // reply byte index, returned length and requested slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txCntQ <= 8'h00;
      lenQ <= 8'h00;
      slotQ <= 8'h00;
      rxCntQ <= 8'h00;
    end else begin
      if (txMoveW) txCntQ <= txLast ? 8'h00 : txCntQ + 8'h01;
      if (txMoveW && txCntQ == 8'h02) lenQ <= txData;
      if (rxValid && rxReady) rxCntQ <= rxLast ? 8'h00 : rxCntQ + 8'h01;
      if (rxValid && rxReady && rxCntQ == 8'h01) slotQ <= rxData;
    end
  end
  a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus answer not zero-wait okay");
  a_unmapped_zero: assert property (hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h10 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_reply_lead: assert property ($rose(txValid) |-> $past(rxEndW, 4) || $past(txMoveW, 3))
    else $error("reply byte at wrong cycle");
  a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast))
    else $error("reply byte dropped while stalled");
  a_rx_block: assert property (txValid |-> !rxReady)
    else $error("request taken during reply");
  a_finish_gap: assert property (rxEnd |=> !rxReady)
    else $error("no gap after datagram end");
  a_first_code: assert property (txValid && txCntQ == 8'h00 |-> txData == SUB_REPLY)
    else $error("reply code wrong");
  a_slot_echo: assert property (txValid && txCntQ == 8'h01 |-> txData == slotQ)
    else $error("reply slot not echoed");
  a_len_bound: assert property (txValid && txCntQ == 8'h02 |-> txData inside {[8'h01:8'h80]})
    else $error("reply length out of bounds");
  a_reply_len: assert property (txMove and txLast |-> txCntQ == lenQ + 8'h02)
    else $error("reply byte count differs from length");
endmodule  // cfg_datagram_handler_asserts
bind cfg_datagram_handler cfg_datagram_handler_asserts u_chk (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hreadyout, .hrdata, .hresp, .rxValid, .rxReady, .rxData, .rxLast, .txValid, .txReady, .txData, .txLast);
`default_nettype wire

// ### tb/cfg_datagram_handler_tb.sv
// self-checking bench for the configuration datagram handler
`timescale 1ns/1ps
`default_nettype none
module cfg_datagram_handler_tb
  import cfg_dgram_pkg::*;
;
  typedef logic [7:0] bq_t[$];
  logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        rxValid, rxReady, rxLast, txValid, txReady, txLast;
  logic [7:0]  rxData, txData, opt;
  logic [15:0] holdLastState, faultReportOff;
  int          failCount, nChecks;
  bq_t         di, own, grp, p0, p1, q;
  logic [7:0]  regs[5] = '{REG_KIND, REG_STATUS, REG_COMMITS, REG_TOTAL, 8'h10};
  logic [7:0]  rq[3] = '{8'h04, 8'h0D, 8'h14};
  logic [7:0]  rl[3] = '{8'h06, 8'h0D, 8'h14};
  assign hready = hreadyout;
  cfg_datagram_handler u_dut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hrdata, .hresp, .rxValid, .rxReady, .rxData, .rxLast, .txValid, .txReady, .txData,
    .txLast, .holdLastState, .faultReportOff);
  cfg_dgram_host u_host (.clk, .rst_n, .rxValid, .rxData, .rxLast, .rxReady, .txValid, .txData,
    .txLast, .txReady);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    nChecks++;
    if (g !== e) begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one single word transfer; each phase held until hready is sampled high
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic rdreg(input logic [7:0] a, input logic [31:0] e, input string nm);
    ahb(1'b0, a, 32'h0, rd);
    chk32(nm, e, rd);
  endtask
  // reply expected for a stored record: code, slot, length, record padded with zeros
  function automatic bq_t mkrep(input logic [7:0] s, input logic [7:0] n, input bq_t rec);
    mkrep = {SUB_REPLY, s, n};
    for (int i = 0; i < int'(n); i++) mkrep.push_back(i < rec.size() ? rec[i] : 8'h00);
  endfunction
  task automatic wrcfg(input bq_t b);
    u_host.send(b);
    repeat (2) @(posedge clk);
  endtask
  task automatic rdcfg(input bq_t req, input bq_t e);
    u_host.rep.delete();
    u_host.send(req);
    for (int k = 0; k < 3000 && u_host.rep.size() < e.size(); k++) @(posedge clk);
    // long enough for a stray extra byte to be offered or taken
    repeat (4) @(posedge clk);
    chk8("reply end", 8'h00, {7'h00, txValid});
    chk32("reply size", e.size(), u_host.rep.size());
    foreach (e[i]) chk8("reply byte", e[i], i < u_host.rep.size() ? u_host.rep[i] : 8'hXX);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, well beyond the few thousand cycles the tests need
  initial begin
    repeat (60000) @(posedge clk);
    failCount++;
    summarize();
  end
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    failCount = 0;
    nChecks = 0;
    void'($urandom(57));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (regs[i]) rdreg(regs[i], 32'h0, "reset register");
    chk32("reset options", 32'h0, {holdLastState, faultReportOff});
    $display("test reset done");
    ahb(1'b1, REG_KIND, 32'h20, rd);  // slot 5 packetised
    rdreg(REG_KIND, 32'h20, "kind");
    // discrete input records with random references and options, read back short, exact and long
    for (int i = 0; i < 3; i++) begin
      opt = 8'($urandom);
      di = {DI_TYPE, 8'h00, 8'h00, 8'h00, 8'($urandom), 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, opt};
      wrcfg({SUB_WRITE, 8'h03, DI_LEN, di});
      rdreg(REG_COMMITS, 32'(i + 1), "commits");
      chk8("options", {6'h0, opt[FAULT_BIT_DEF], opt[HOLD_BIT_DEF]}, {6'h0, faultReportOff[3], holdLastState[3]});
      rdcfg({SUB_READ, 8'h03, rq[i]}, mkrep(8'h03, rl[i], di));
    end
    $display("test conventional done");
    q = di;
    void'(q.pop_back());
    wrcfg({SUB_WRITE, 8'h03, 8'h0C, q});
    rdreg(REG_COMMITS, 32'h3, "commits");
    rdreg(REG_STATUS, 32'h100, "status");
    rdcfg({SUB_READ, 8'h03, DI_LEN}, mkrep(8'h03, DI_LEN, di));
    ahb(1'b1, REG_STATUS, 32'hF00, rd);
    wrcfg({8'h09, 8'h00});
    rdreg(REG_STATUS, 32'h800, "status");
    ahb(1'b1, REG_STATUS, 32'hF00, rd);
    $display("test refusals done");
    own = {OWN_TAG};
    for (int i = 0; i < 128; i++) begin
      p0.push_back(8'($urandom));
      if (i < 20) p1.push_back(8'($urandom));
      if (i < 8) grp.push_back(8'($urandom));
      if (i < 11) own.push_back(8'h00);
      else if (i < 15) own.push_back(8'($urandom));
    end
    u_host.stall = 1'b1;
    // framed update in slot and packet order, full first packet
    wrcfg({SUB_BEGIN});
    wrcfg({SUB_WRITE, 8'h00, 8'h10, own});
    wrcfg({SUB_WRITE, 8'h00, 8'h08, SEL_GRP_LO, grp});
    wrcfg({SUB_WRITE, 8'h05, PKT_MAX, p0});
    wrcfg({SUB_WRITE, 8'h15, 8'h14, p1});
    rdreg(REG_STATUS, 32'h1, "status");
    rdreg(REG_TOTAL, 32'd181, "total");
    rdcfg({SUB_READ, 8'h05, 8'h14}, mkrep(8'h05, 8'h14, '{}));
    wrcfg({SUB_END, 8'hB5, 8'h00});
    rdreg(REG_COMMITS, 32'h4, "commits");
    rdreg(REG_STATUS, 32'h0, "status");
    rdcfg({SUB_READ, 8'h00, 8'h10}, mkrep(8'h00, 8'h10, own));
    rdcfg({SUB_READ, 8'h00, 8'h10, SEL_OWN}, mkrep(8'h00, 8'h10, own));
    rdcfg({SUB_READ, 8'h00, 8'h08, SEL_GRP_LO}, mkrep(8'h00, 8'h08, grp));
    rdcfg({SUB_READ, 8'h00, 8'h04, SEL_GRP_HI}, mkrep(8'h00, 8'h04, '{}));
    rdcfg({SUB_READ, 8'h15, 8'h14}, mkrep(8'h15, 8'h14, p1));
    rdcfg({SUB_READ, 8'h05, 8'hC8}, mkrep(8'h05, PKT_MAX, p0));
    $display("test framed done");
    wrcfg({SUB_BEGIN});
    wrcfg({SUB_WRITE, 8'h00, 8'h10, own});
    wrcfg({SUB_END, 8'h01, 8'h00});
    rdreg(REG_STATUS, 32'h400, "status");
    rdreg(REG_COMMITS, 32'h4, "commits");
    wrcfg({SUB_WRITE, 8'h00, 8'h10, SEL_OWN, own});
    rdcfg({SUB_READ, 8'h00, 8'h10}, mkrep(8'h00, 8'h10, own));
    $display("test bad total done");
    summarize();
  end
endmodule  // cfg_datagram_handler_tb
`default_nettype wire

// ### tb/cfg_dgram_host.sv
// host-side model: sends request datagrams and collects reply bytes
`timescale 1ns/1ps
`default_nettype none
module cfg_dgram_host (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // request stream towards the node
  output logic            rxValid,
  output logic [7:0]      rxData,
  output logic            rxLast,
  input  wire logic       rxReady,
  // reply stream from the node
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  input  wire logic       txLast,
  output logic            txReady
);
  logic [7:0] rep[$];
  logic       stall = 1'b0;
  initial begin
    rxValid = 1'b0;
    rxData = 8'hA5;
    rxLast = 1'b0;
    txReady = 1'b0;
  end
  // take reply bytes; a slow host stalls at random
  always @(posedge clk) begin
    if (txValid && txReady) rep.push_back(txData);
    txReady <= rst_n && (!stall || $urandom_range(0, 2) == 0);
  end
  // code byte first, each byte held until the node takes it, last one flagged
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      rxValid <= 1'b1;
      rxData <= b[i];
      rxLast <= (i == b.size() - 1);
      do @(posedge clk); while (rxReady !== 1'b1);
    end
    rxValid <= 1'b0;
    rxLast <= 1'b0;
    rxData <= ~rxData;  // released lines must not keep the last byte
  endtask
endmodule  // cfg_dgram_host
`default_nettype wire
